// File: hdl/vcm_pkg.sv
// Package of the vacuum condition monitor: parameter indices, field positions and timing.
// Assumes a 100 MHz system clock and a parameter port with 8-bit indices.
package vcm_pkg;

  // ==========================================================================
  // Parameter indices.
  localparam logic [7:0] IDX_PERM_EVAC  = 8'h6b;
  localparam logic [7:0] IDX_PERM_LEAK  = 8'h6c;
  localparam logic [7:0] IDX_WARN       = 8'h92;
  localparam logic [7:0] IDX_T0         = 8'h94;
  localparam logic [7:0] IDX_T1         = 8'h95;
  localparam logic [7:0] IDX_ENERGY     = 8'h9d;
  localparam logic [7:0] IDX_LEAK       = 8'ha0;
  localparam logic [7:0] IDX_FREE_FLOW  = 8'ha1;
  localparam logic [7:0] IDX_QUALITY    = 8'ha2;
  localparam logic [7:0] IDX_PERFORM    = 8'ha3;
  localparam logic [7:0] IDX_PEAK_TEMP  = 8'ha9;

  // ==========================================================================
  // Warning bit positions.
  localparam int W_SETPOINT_LOW  = 0;
  localparam int W_EVAC_LONG     = 1;
  localparam int W_LEAK_HIGH     = 2;
  localparam int W_SP_MISSED     = 3;
  localparam int W_FREE_FLOW     = 4;
  localparam int W_ROBOT         = 5;
  localparam int W_PART_LOST     = 6;
  localparam int W_OVERTEMP      = 7;
  localparam int ROBOT_WARN_BIT  = 2;

  // ==========================================================================
  // Telemetry selector codes for output byte 0.
  localparam logic [7:0] SEL_T0      = 8'h00;
  localparam logic [7:0] SEL_T1      = 8'h01;
  localparam logic [7:0] SEL_LEAK    = 8'h02;
  localparam logic [7:0] SEL_ENERGY  = 8'h03;
  localparam logic [7:0] SEL_FLOW    = 8'h04;
  localparam logic [7:0] SEL_QUALITY = 8'h05;
  localparam logic [7:0] SEL_PERFORM = 8'h06;

  // ==========================================================================
  // Limits and timing.
  localparam int          CLK_HZ           = 100_000_000;
  localparam int          MS_NS            = 1_000_000;
  localparam int          CYC_PER_MS       = MS_NS / 10;
  localparam int          FREE_FLOW_MS     = 1000;
  localparam logic [15:0] EVAC_MAX_MS      = 16'h03e7 * 16'h000a;
  localparam logic [15:0] FREE_FLOW_MIN    = 16'h0005;
  localparam logic [15:0] TEMP_LIMIT       = 16'h0032;
  localparam logic [15:0] RATING_FULL      = 16'h0064;
  localparam logic [15:0] EVAC_RESET       = 16'h0000;
  localparam logic [15:0] PERM_EVAC_RESET  = 16'h0000;
  localparam logic [15:0] PERM_LEAK_RESET  = 16'hffff;

  typedef struct packed {
    logic [7:0]  sel;
    logic        autoset_req;
    logic [7:0]  robot_byte;
  } vcm_pdout_t;

  typedef struct packed {
    logic        autoset_ack;
    logic [15:0] telemetry;
  } vcm_pdin_t;

endpackage : vcm_pkg

// File: hdl/vcm_monitor.sv
// Condition, energy and wear supervision of the vacuum generator, one suction cycle at a time.
// Assumes pressure, temperature and pump figures arrive from the controller's own clocked logic;
// suction, button and robot bytes come from pins or the link and are synchronised here.
`timescale 1ns/10ps
module vcm_monitor
  import vcm_pkg::*;
#(
  parameter int          MS_CYCLES   = CYC_PER_MS,
  parameter int          FLOW_MS     = FREE_FLOW_MS,
  parameter logic [15:0] TOL_PERCENT = 16'h0014
) (
  input  wire logic        CLK_SYS,
  input  wire logic        RST_N,
  input  wire logic        SUCTION_CMD,
  input  wire logic        BUTTON,
  input  wire vcm_pdout_t  PD_OUT,
  input  wire logic [15:0] VACUUM,
  input  wire logic [15:0] CONTROL_SETPOINT_VACUUM,
  input  wire logic [15:0] PART_PRESENT_VACUUM_LIMIT,
  input  wire logic [15:0] PART_PRESENT_HYSTERESIS,
  input  wire logic        CONTROL_MODE,
  input  wire logic [15:0] PUMP_SPEED,
  input  wire logic        PUMP_ON,
  input  wire logic [15:0] POWER_W,
  input  wire logic [15:0] TEMPERATURE,
  input  wire logic        PAR_WR,
  input  wire logic [7:0]  PAR_IDX,
  input  wire logic [15:0] PAR_WDATA,
  output logic      [15:0] PAR_RDATA,
  output vcm_pdin_t        PD_IN,
  output logic             STATUS_YELLOW,
  output logic             WARN_ORANGE
);

  // ==========================================================================
  // State.
  typedef enum logic [1:0] {VCM_IDLE, VCM_EVAC0, VCM_EVAC1, VCM_HOLD} vcm_phase_t;

  typedef struct packed {
    logic [1:0]  suc_s1, suc_s2, btn_s1, btn_s2, as_s1, as_s2;
    logic [7:0]  rob_s1, rob_s2, sel_s1, sel_s2;
    logic        suc_prev, as_prev, btn_prev;
    vcm_phase_t  phase;
    logic [31:0] ms_div;
    logic [15:0] t0, t1, perm_evac, perm_leak, warn_low;
    logic [7:0]  warn;
    logic        sp_seen, pp_seen;
    logic [15:0] leak, quality, flow, perform;
    logic [31:0] energy_acc;
    logic [15:0] energy, peak_temp;
    logic [15:0] flow_ms;
    logic        flow_run;
    logic        ack;
    logic [15:0] rdata, tele;
  } vcm_state_t;

  vcm_state_t q, d;

  function automatic logic [15:0] sat_inc(input logic [15:0] v);
    sat_inc = (v == 16'hffff) ? v : v + 16'h0001;
  endfunction : sat_inc

  function automatic logic [15:0] pct_of(input logic [15:0] v, input logic [15:0] lim);
    logic [31:0] p;
    p = 32'(v) * 32'(RATING_FULL) / ((lim == 16'h0000) ? 32'h1 : 32'(lim));
    pct_of = (p > 32'(RATING_FULL)) ? 16'h0000 : RATING_FULL - p[15:0];
  endfunction : pct_of

  function automatic logic [15:0] add_tol(input logic [15:0] v);
    logic [31:0] s;
    s = 32'(v) + 32'(v) * 32'(TOL_PERCENT) / 32'(RATING_FULL);
    add_tol = (s > 32'h0000ffff) ? 16'hffff : s[15:0];
  endfunction : add_tol

  logic        suc, btn, as_req, cyc_start, cyc_end, ms_tick;
  logic [15:0] hyst_lim;
  logic [15:0] leak_sample;

  always_comb begin
    d           = q;
    d.suc_s1    = {1'b0, SUCTION_CMD};
    d.suc_s2    = q.suc_s1;
    d.btn_s1    = {1'b0, BUTTON};
    d.btn_s2    = q.btn_s1;
    d.as_s1     = {1'b0, PD_OUT.autoset_req};
    d.as_s2     = q.as_s1;
    d.rob_s1    = PD_OUT.robot_byte;
    d.rob_s2    = q.rob_s1;
    d.sel_s1    = PD_OUT.sel;
    d.sel_s2    = q.sel_s1;
    suc         = q.suc_s2[0];
    btn         = q.btn_s2[0];
    as_req      = q.as_s2[0];
    d.suc_prev  = suc;
    d.btn_prev  = btn;
    d.as_prev   = as_req;
    cyc_start   = suc && !q.suc_prev;
    cyc_end     = !suc && q.suc_prev;
    hyst_lim    = (PART_PRESENT_VACUUM_LIMIT > PART_PRESENT_HYSTERESIS) ?
                  PART_PRESENT_VACUUM_LIMIT - PART_PRESENT_HYSTERESIS : 16'h0000;
    ms_tick     = (q.ms_div == 32'(MS_CYCLES - 1));
    d.ms_div    = ms_tick ? 32'h0 : q.ms_div + 32'h1;
    leak_sample = 16'(32'(PUMP_SPEED) * (PUMP_ON ? 32'h1 : 32'h0));

    // ========================================================================
    // Parameter writes; evacuation limit capped at the largest accepted setting, leak limit taken as written.
    if (PAR_WR && PAR_IDX == IDX_PERM_EVAC) begin
      d.perm_evac = (PAR_WDATA > EVAC_MAX_MS) ? EVAC_MAX_MS : PAR_WDATA;
    end
    if (PAR_WR && PAR_IDX == IDX_PERM_LEAK) begin
      d.perm_leak = PAR_WDATA;
    end

    // ========================================================================
    // Continuous bits.
    d.warn[W_SETPOINT_LOW] = CONTROL_SETPOINT_VACUUM < PART_PRESENT_VACUUM_LIMIT;
    d.warn[W_ROBOT]        = q.rob_s2[ROBOT_WARN_BIT];
    d.warn[W_OVERTEMP]     = TEMPERATURE > TEMP_LIMIT;
    if (TEMPERATURE > q.peak_temp) begin
      d.peak_temp = TEMPERATURE;
    end

    // ========================================================================
    // Suction cycle.
    if (ms_tick) begin
      d.energy_acc = q.energy_acc + 32'(POWER_W);
    end
    if (cyc_start) begin
      d.phase    = VCM_EVAC0;
      d.ms_div   = 32'h0;
      d.t0       = EVAC_RESET;
      d.t1       = EVAC_RESET;
      d.leak     = 16'h0000;
      d.quality  = RATING_FULL;
      d.sp_seen  = 1'b0;
      d.pp_seen  = 1'b0;
      d.warn[W_EVAC_LONG] = 1'b0;
      d.warn[W_LEAK_HIGH] = 1'b0;
      d.warn[W_SP_MISSED] = 1'b0;
      d.warn[W_PART_LOST] = 1'b0;
      d.energy     = q.energy_acc[15:0];
      d.energy_acc = 32'(POWER_W);
      d.flow_run = 1'b1;
      d.flow_ms  = 16'h0000;
    end else begin
      if (btn && !q.btn_prev) begin
        d.warn[W_PART_LOST] = 1'b0;
      end
      case (q.phase)
        VCM_IDLE: begin
          d.phase = VCM_IDLE;
        end
        VCM_EVAC0: begin
          if (VACUUM >= PART_PRESENT_VACUUM_LIMIT) begin
            d.phase   = VCM_EVAC1;
            d.pp_seen = 1'b1;
          end else if (ms_tick) begin
            d.t0 = sat_inc(q.t0);
          end
        end
        VCM_EVAC1: begin
          if (VACUUM >= CONTROL_SETPOINT_VACUUM) begin
            d.phase   = VCM_HOLD;
            d.sp_seen = 1'b1;
          end else if (ms_tick) begin
            d.t1 = sat_inc(q.t1);
          end
          if (q.perm_evac != 16'h0000 && q.t1 > q.perm_evac) begin
            d.warn[W_EVAC_LONG] = 1'b1;
          end
        end
        VCM_HOLD: begin
          if (CONTROL_MODE && ms_tick) begin
            d.leak    = 16'((32'(q.leak) * 32'h3 + 32'(leak_sample)) >> 2);
            d.quality = pct_of(d.leak, q.perm_leak);
          end
          if (d.leak > q.perm_leak) begin
            d.warn[W_LEAK_HIGH] = 1'b1;
          end
          if (VACUUM < hyst_lim) begin
            d.warn[W_PART_LOST] = 1'b1;
          end
        end
        default: d.phase = VCM_IDLE;
      endcase
      if (cyc_end) begin
        d.phase = VCM_IDLE;
        if (!q.sp_seen && !(VACUUM >= CONTROL_SETPOINT_VACUUM)) begin
          d.warn[W_SP_MISSED] = 1'b1;
        end
      end
    end

    // ========================================================================
    // Free-flow measurement during the first second of unobstructed suction.
    if (q.flow_run && !cyc_start) begin
      if (!suc || VACUUM >= PART_PRESENT_VACUUM_LIMIT) begin
        d.flow_run = 1'b0;
      end else if (ms_tick) begin
        d.flow_ms = q.flow_ms + 16'h0001;
        if (q.flow_ms == 16'(FLOW_MS - 1)) begin
          d.flow_run = 1'b0;
          if (VACUUM >= FREE_FLOW_MIN && VACUUM <= CONTROL_SETPOINT_VACUUM) begin
            d.flow = VACUUM;
            d.warn[W_FREE_FLOW] = (VACUUM > hyst_lim) && (VACUUM < CONTROL_SETPOINT_VACUUM);
            d.perform = (VACUUM > hyst_lim || VACUUM == 16'h0000) ? 16'h0000 :
                        pct_of(VACUUM, hyst_lim);
          end
        end
      end
    end

    // ========================================================================
    // Autoset: learned limits from the last cycle, acknowledged on byte 0.
    if (as_req && !q.as_prev) begin
      d.perm_leak = add_tol(q.leak);
      d.perm_evac = (add_tol(q.t1) > EVAC_MAX_MS) ? EVAC_MAX_MS : add_tol(q.t1);
      d.ack       = 1'b1;
    end else if (!as_req) begin
      d.ack = 1'b0;
    end

    // ========================================================================
    // Read-back and selected telemetry.
    case (PAR_IDX)
      IDX_PERM_EVAC: d.rdata = q.perm_evac;
      IDX_PERM_LEAK: d.rdata = q.perm_leak;
      IDX_WARN:      d.rdata = {8'h00, q.warn};
      IDX_T0:        d.rdata = q.t0;
      IDX_T1:        d.rdata = q.t1;
      IDX_ENERGY:    d.rdata = q.energy;
      IDX_LEAK:      d.rdata = q.leak;
      IDX_FREE_FLOW: d.rdata = q.flow;
      IDX_QUALITY:   d.rdata = q.quality;
      IDX_PERFORM:   d.rdata = q.perform;
      IDX_PEAK_TEMP: d.rdata = q.peak_temp;
      default:       d.rdata = 16'h0000;
    endcase
    case (q.sel_s2)
      SEL_T0:      d.tele = q.t0;
      SEL_T1:      d.tele = q.t1;
      SEL_LEAK:    d.tele = q.leak;
      SEL_ENERGY:  d.tele = q.energy;
      SEL_FLOW:    d.tele = q.flow;
      SEL_QUALITY: d.tele = q.quality;
      SEL_PERFORM: d.tele = q.perform;
      default:     d.tele = 16'h0000;
    endcase
  end

  // Constants only under reset; free-flow and performance start at zero meaning unknown.
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      q           <= '0;
      q.phase     <= VCM_IDLE;
      q.perm_evac <= PERM_EVAC_RESET;
      q.perm_leak <= PERM_LEAK_RESET;
    end else begin
      q <= d;
    end
  end

  assign PAR_RDATA         = q.rdata;
  assign PD_IN.autoset_ack = q.ack;
  assign PD_IN.telemetry   = q.tele;
  assign STATUS_YELLOW     = |q.warn;
  assign WARN_ORANGE       = q.warn[W_LEAK_HIGH] | q.warn[W_FREE_FLOW];

endmodule : vcm_monitor

// File: testbench/vcm_monitor_sva.sv
// Assertion checker of the vacuum condition monitor, bound to the top module's ports.
// Assumes the monitor's package and one clock domain with an active-low reset.
`timescale 1ns/10ps
module vcm_monitor_sva
  import vcm_pkg::*;
(
  input wire logic        CLK_SYS,
  input wire logic        RST_N,
  input wire vcm_pdout_t  PD_OUT,
  input wire logic [15:0] CONTROL_SETPOINT_VACUUM,
  input wire logic [15:0] PART_PRESENT_VACUUM_LIMIT,
  input wire logic [15:0] TEMPERATURE,
  input wire logic        PAR_WR,
  input wire logic [7:0]  PAR_IDX,
  input wire logic [15:0] PAR_WDATA,
  input wire logic [15:0] PAR_RDATA,
  input wire vcm_pdin_t   PD_IN,
  input wire logic        STATUS_YELLOW,
  input wire logic        WARN_ORANGE
);
  // ==========================================================================
  // Properties.
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_N);
  sequence warn_read;
    PAR_IDX == IDX_WARN;
  endsequence
  sequence req_held;
    $rose(PD_OUT.autoset_req) ##1 PD_OUT.autoset_req[*4];
  endsequence
  a_evac_clamp: assert property (PAR_IDX == IDX_PERM_EVAC |=> PAR_RDATA <= 16'h2706)
    else $error("evacuation limit above ceiling");
  a_perm_write: assert property (PAR_WR && PAR_IDX == IDX_PERM_EVAC && PAR_WDATA <= 16'h2706 ##1
    PAR_IDX == IDX_PERM_EVAC && !PAR_WR |=> PAR_RDATA == $past(PAR_WDATA, 2)) else $error("limit not stored");
  a_orange_yellow: assert property (WARN_ORANGE |-> STATUS_YELLOW) else $error("orange without yellow");
  a_ack_rise: assert property (req_held |-> ##[0:6] PD_IN.autoset_ack) else $error("autoset not acked");
  a_ack_drop: assert property ($fell(PD_OUT.autoset_req) |-> ##[1:5] !PD_IN.autoset_ack)
    else $error("acknowledge stuck");
  a_sel_invalid: assert property ((PD_OUT.sel > SEL_PERFORM)[*6] |-> PD_IN.telemetry == 16'h0000)
    else $error("unknown selector gives data");
  a_robot_mirror: assert property (PD_OUT.robot_byte[ROBOT_WARN_BIT][*8] ##0 warn_read |=> PAR_RDATA[W_ROBOT])
    else $error("robot warning not mirrored");
  a_temp_bit: assert property ((TEMPERATURE > TEMP_LIMIT)[*8] ##0 warn_read |=> PAR_RDATA[W_OVERTEMP])
    else $error("temperature warning missing");
  a_setpoint_low: assert property ((CONTROL_SETPOINT_VACUUM < PART_PRESENT_VACUUM_LIMIT)[*8] ##0 warn_read
    |=> PAR_RDATA[W_SETPOINT_LOW]) else $error("setpoint below limit not flagged");
endmodule : vcm_monitor_sva
bind vcm_monitor vcm_monitor_sva i_sva (.CLK_SYS, .RST_N, .PD_OUT, .CONTROL_SETPOINT_VACUUM,
  .PART_PRESENT_VACUUM_LIMIT, .TEMPERATURE, .PAR_WR, .PAR_IDX, .PAR_WDATA, .PAR_RDATA, .PD_IN,
  .STATUS_YELLOW, .WARN_ORANGE);

// File: testbench/vcm_master.sv
// Model of the link master that owns the output process data of the monitor.
// Assumes the monitor's clock; requests change just after a rising edge.
`timescale 1ns/10ps
module vcm_master
  import vcm_pkg::*;
(
  input wire logic      clk_sys,
  input wire vcm_pdin_t pd_in,
  output vcm_pdout_t    pd_out
);
  // ==========================================================================
  // Process data requests.
  initial pd_out = '0;
  task automatic set_sel(input logic [7:0] s);
    @(posedge clk_sys);
    pd_out.sel <= s;
  endtask : set_sel
  task automatic set_robot(input logic w);
    @(posedge clk_sys);
    pd_out.robot_byte[ROBOT_WARN_BIT] <= w;
  endtask : set_robot
  // The request is held past the acknowledge, since the device sees it only after synchronising.
  task automatic autoset(output logic ok);
    int n;
    ok = 1'b0;
    @(posedge clk_sys);
    pd_out.autoset_req <= 1'b1;
    for (n = 0; n < 40 && !ok; n++) begin
      @(posedge clk_sys);
      ok = (pd_in.autoset_ack === 1'b1);
    end
    repeat (4) @(posedge clk_sys);
    pd_out.autoset_req <= 1'b0;
  endtask : autoset
endmodule : vcm_master

// File: testbench/vacuum_condition_monitor_tb.sv
// Testbench of the vacuum condition monitor: parameters, suction cycles, telemetry and autoset.
// Assumes the monitor built with ten clocks to the millisecond and a five-millisecond free-flow window.
`timescale 1ns/10ps
module vacuum_condition_monitor_tb;
  import vcm_pkg::*;
  localparam int MSC = 10;
  logic        clk_sys = 1'b0, rst_n = 1'b0, suction = 1'b0, mode = 1'b0, pump_on = 1'b0, ok;
  logic        par_wr = 1'b0, yellow, orange, button = 1'b0;
  logic [7:0]  par_idx = 8'h00;
  logic [15:0] vacuum = '0, setp = 16'h0190, part = 16'h00c8, speed = '0, temp = 16'h0019;
  logic [15:0] power = 16'h0001, hyst = 16'h0014;
  logic [15:0] par_wdata = '0, par_rdata, d;
  vcm_pdout_t  pd_out;
  vcm_pdin_t   pd_in;
  int          num_errors = 0, samples_checked = 0;
  always #5 clk_sys = ~clk_sys;
  vcm_master i_master (.clk_sys(clk_sys), .pd_in(pd_in), .pd_out(pd_out));
  vcm_monitor #(.MS_CYCLES(MSC), .FLOW_MS(5)) i_dut (.CLK_SYS(clk_sys), .RST_N(rst_n),
    .SUCTION_CMD(suction), .BUTTON(button), .PD_OUT(pd_out), .VACUUM(vacuum), .CONTROL_SETPOINT_VACUUM(setp),
    .PART_PRESENT_VACUUM_LIMIT(part), .PART_PRESENT_HYSTERESIS(hyst), .CONTROL_MODE(mode),
    .PUMP_SPEED(speed), .PUMP_ON(pump_on), .POWER_W(power), .TEMPERATURE(temp), .PAR_WR(par_wr),
    .PAR_IDX(par_idx), .PAR_WDATA(par_wdata), .PAR_RDATA(par_rdata), .PD_IN(pd_in),
    .STATUS_YELLOW(yellow), .WARN_ORANGE(orange));
  // ==========================================================================
  // Access and compare tasks.
  task automatic chk(input string nm, input logic [15:0] e, g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic chkr(input string nm, input logic [15:0] lo, hi, g);
    samples_checked++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      num_errors++;
      $display("wrong value %s expected %h to %h seen %h", nm, lo, hi, g);
    end
  endtask : chkr
  task automatic rd(input logic [7:0] i);
    @(posedge clk_sys);
    par_idx <= i;
    repeat (2) @(posedge clk_sys);
    d = par_rdata;
  endtask : rd
  task automatic wr(input logic [7:0] i, input logic [15:0] v);
    @(posedge clk_sys);
    par_wr    <= 1'b1;
    par_idx   <= i;
    par_wdata <= v;
    @(posedge clk_sys);
    par_wr <= 1'b0;
  endtask : wr
  task automatic ms(input int n);
    repeat (n * MSC) @(posedge clk_sys);
  endtask : ms
  task automatic done(input string nm);
    $display("test %s finished", nm);
  endtask : done
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  // ==========================================================================
  // Tests.
  initial begin
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(IDX_PERM_EVAC); chk("evac limit reset", PERM_EVAC_RESET, d);
    rd(IDX_PERM_LEAK); chk("leak limit reset", PERM_LEAK_RESET, d);
    rd(IDX_WARN); chk("warnings reset", 16'h0000, d);
    wr(IDX_PERM_EVAC, 16'hffff);
    rd(IDX_PERM_EVAC); chk("evac limit clamp", 16'h2706, d);
    wr(IDX_T0, 16'h1234);
    rd(IDX_T0); chk("read-only t0", 16'h0000, d);
    done("registers");
    wr(IDX_PERM_EVAC, 16'h0000);
    vacuum <= 16'h0064;
    suction <= 1'b1;
    ms(8);
    suction <= 1'b0;
    ms(1);
    rd(IDX_WARN); chk("setpoint missed", 16'h0008, d);
    rd(IDX_FREE_FLOW); chk("free flow", 16'h0064, d);
    done("missed setpoint");
    wr(IDX_PERM_EVAC, 16'h0003);
    wr(IDX_PERM_LEAK, 16'h0000);
    mode <= 1'b1;
    pump_on <= 1'b1;
    speed <= 16'h0064;
    vacuum <= 16'h00be;
    suction <= 1'b1;
    ms(8);
    vacuum <= 16'h012c;
    ms(6);
    vacuum <= 16'h0190;
    ms(4);
    suction <= 1'b0;
    ms(1);
    rd(IDX_WARN); chk("cycle warnings", 16'h0016, d);
    chk("status yellow", 16'h0001, {15'h0000, yellow});
    chk("orange warning", 16'h0001, {15'h0000, orange});
    rd(IDX_T0); chkr("initial evac time", 16'h0006, 16'h0009, d);
    rd(IDX_T1); chkr("setpoint evac time", 16'h0005, 16'h0007, d);
    rd(IDX_LEAK); chkr("leak rate", 16'h0001, 16'hffff, d);
    rd(IDX_FREE_FLOW); chk("free flow", 16'h00be, d);
    rd(IDX_PERFORM); chk("performance", 16'h0000, d);
    rd(IDX_QUALITY); chk("quality at zero limit", 16'h0000, d);
    i_master.set_sel(SEL_FLOW);
    ms(1);
    chk("telemetry flow", 16'h00be, pd_in.telemetry);
    i_master.set_sel(8'h07);
    ms(1);
    chk("telemetry unknown", 16'h0000, pd_in.telemetry);
    done("full cycle");
    i_master.set_robot(1'b1);
    temp <= 16'h003c;
    setp <= 16'h0064;
    ms(1);
    rd(IDX_WARN); chk("continuous bits", 16'h00b7, d);
    rd(IDX_PEAK_TEMP); chk("peak temperature", 16'h003c, d);
    i_master.set_robot(1'b0);
    temp <= 16'h0019;
    setp <= 16'h0190;
    ms(1);
    done("continuous bits");
    i_master.autoset(ok);
    chk("autoset ack", 16'h0001, {15'h0000, ok});
    rd(IDX_PERM_EVAC); chkr("learned evac limit", 16'h0005, 16'h0009, d);
    done("autoset");
    mode <= 1'b0;
    vacuum <= 16'h0000;
    suction <= 1'b1;
    ms(2);
    rd(IDX_WARN); chk("warnings at start", 16'h0010, d);
    rd(IDX_T1); chk("t1 cleared", 16'h0000, d);
    rd(IDX_T0); chkr("t0 restarted", 16'h0001, 16'h0003, d);
    rd(IDX_LEAK); chk("leak cleared", 16'h0000, d);
    rd(IDX_QUALITY); chk("quality restarted", RATING_FULL, d);
    rd(IDX_ENERGY); chkr("previous cycle energy", 16'h0016, 16'h0022, d);
    vacuum <= 16'h0190;
    ms(1);
    vacuum <= 16'h0064;
    ms(1);
    rd(IDX_WARN); chk("part lost", 16'h0050, d);
    suction <= 1'b0;
    ms(1);
    button <= 1'b1;
    ms(1);
    button <= 1'b0;
    rd(IDX_WARN); chk("button acknowledge", 16'h0010, d);
    done("new cycle");
    tally_and_finish();
  end
  // About 490 clocks of tests; the watchdog allows some forty times that.
  initial begin
    #200_000;
    num_errors++;
    tally_and_finish();
  end
endmodule : vacuum_condition_monitor_tb
